// *** core/stage_seq_pkg.sv ***
package stage_seq_pkg;

	// ==========================================
	// Register offsets
	localparam logic [7:0] OFS_SYS_CTRL    = 8'h05;
	localparam logic [7:0] OFS_GROUP_SEL   = 8'h19;
	localparam logic [7:0] OFS_CHARGE      = 8'h1a;
	localparam logic [7:0] OFS_TRIM        = 8'h1b;
	localparam logic [7:0] OFS_FAULT_RESET = 8'h1c;

	// ==========================================
	// Field positions and channel count
	localparam int SYS_SHUTDOWN_BIT = 6;
	localparam int SYS_SURROUND_BIT = 5;
	localparam int TRIM_DONE_BIT    = 6;
	localparam int TRIM_FIELD_BIT   = 1;
	localparam int TRIM_CMD_BIT     = 0;
	localparam int NUM_CHANNELS     = 6;

	// ==========================================
	// Values after reset
	localparam logic [7:0] SYS_CTRL_RESET    = 8'h60;
	localparam logic [7:0] GROUP_SEL_RESET   = 8'h00;
	localparam logic [7:0] CHARGE_RESET      = 8'h00;
	localparam logic [7:0] FAULT_RESET_RESET = 8'h00;

	// ==========================================
	// Timing: periods counted in ticks of 0.1 ms
	localparam int CLK_PERIOD_NS = 8;
	localparam int TICK_TIME_NS  = 100000;
	localparam int TICK_CYCLES   = TICK_TIME_NS / CLK_PERIOD_NS;
	localparam int TICK_W        = 17;
	localparam int PRESCALE_W    = 14;
	// Fault hold figures in ticks: step 1.3 ms, ceiling 13 ms
	localparam logic [16:0] FAULT_STEP_TICKS = 17'h0000d;
	localparam logic [16:0] FAULT_MIN_TICKS  = 17'h00001;
	localparam logic [16:0] FAULT_MAX_TICKS  = 17'h00082;
	localparam logic [3:0]  FAULT_MAX_CODE   = 4'ha;

	// ==========================================
	// Carriers
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} reg_req_t;

	typedef enum {
		ST_SHUTDOWN,
		ST_CHARGE,
		ST_RUN,
		ST_FAULT_HOLD
	} seq_state_t;

endpackage

// *** core/period_timer.sv ***
`timescale 1ns/1ns
module period_timer
	import stage_seq_pkg::*;
#(
	parameter int TICK_LEN = TICK_CYCLES
)(
	input  wire logic                    core_clk,
	input  wire logic                    rst,
	input  wire logic                    ce,
	input  wire logic                    start,
	input  wire logic [TICK_W-1:0]       ticks,
	output logic                         busy,
	output logic                         done
);
	import stage_seq_pkg::*;

	localparam logic [PRESCALE_W-1:0] PRE_LAST =
		PRESCALE_W'(TICK_LEN - 1);

	logic [PRESCALE_W-1:0] prescale;
	logic [PRESCALE_W-1:0] next_prescale;
	logic [TICK_W-1:0]     remain;
	logic [TICK_W-1:0]     next_remain;
	logic                  next_busy;
	logic                  next_done;

	// ==========================================
	// Countdown; a new start always restarts it
	always_comb
	begin
		next_prescale = prescale;
		next_remain   = remain;
		next_busy     = busy;
		next_done     = 1'b0;
		if (start)
		begin
			next_prescale = '0;
			next_remain   = ticks;
			next_busy     = (ticks != '0);
			next_done     = (ticks == '0);
		end
		else if (busy)
		begin
			if (prescale == PRE_LAST)
			begin
				next_prescale = '0;
				next_remain   = remain - 1'b1;
				if (remain == TICK_W'(1))
				begin
					next_busy = 1'b0;
					next_done = 1'b1;
				end
			end
			else
				next_prescale = prescale + 1'b1;
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			prescale <= '0;
			remain   <= '0;
			busy     <= 1'b0;
			done     <= 1'b0;
		end
		else if (ce)
		begin
			prescale <= next_prescale;
			remain   <= next_remain;
			busy     <= next_busy;
			done     <= next_done;
		end
	end

endmodule

// *** core/stage_sequencer.sv ***
`timescale 1ns/1ns
module stage_sequencer
	import stage_seq_pkg::*;
#(
	parameter int TICK_LEN = TICK_CYCLES
)(
	input  wire logic                           core_clk,
	input  wire logic                           rst,
	input  wire logic                           ce,
	input  wire stage_seq_pkg::reg_req_t        reg_req,
	output logic [7:0]                          rd_data,
	output logic                                rd_valid,
	input  wire logic                           backend_fault_input,
	input  wire logic                           split_cap_mode,
	input  wire logic                           trim_complete,
	output logic                                trim_start,
	output logic                                trim_field_select,
	output logic                                group1_stage_reset,
	output logic                                group2_stage_reset,
	output logic [stage_seq_pkg::NUM_CHANNELS-1:0] pwm_enable
);
	import stage_seq_pkg::*;

	// ==========================================
	// Period decoding
	function automatic logic [TICK_W-1:0] charge_ticks(
		input logic [4:0] code
	);
		logic [TICK_W-1:0] base;
		base = '0;
		case (code[2:0])
			3'h0: base = 17'd130;
			3'h1: base = 17'd169;
			3'h2: base = 17'd234;
			3'h3: base = 17'd312;
			3'h4: base = 17'd416;
			3'h5: base = 17'd546;
			3'h6: base = 17'd728;
			default: base = 17'd962;
		endcase
		// Decades: 01xxx x1, 10xxx x10, 11xxx x100 of the 13 ms row
		case (code[4:3])
			2'b01: charge_ticks = base;
			// Code 10001 is the one row that breaks the x10 pattern
			2'b10: charge_ticks = (code[2:0] == 3'h1) ? 17'd1560
				: TICK_W'(base * 10);
			2'b11: charge_ticks = TICK_W'(base * 100);
			default: charge_ticks = '0;
		endcase
	endfunction

	function automatic logic [TICK_W-1:0] fault_ticks(
		input logic [3:0] code
	);
		if (code == 4'h0)
			fault_ticks = FAULT_MIN_TICKS;
		else if (code >= FAULT_MAX_CODE)
			fault_ticks = FAULT_MAX_TICKS;
		else
			fault_ticks = TICK_W'(FAULT_STEP_TICKS * code);
	endfunction

	// ==========================================
	// Pin synchronisers
	logic [2:0] fault_sync;
	logic [1:0] split_sync;
	logic [1:0] done_sync;
	logic       fault_event;

	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			fault_sync <= '0;
			split_sync <= '0;
			done_sync  <= '0;
		end
		else if (ce)
		begin
			fault_sync <= {fault_sync[1:0], backend_fault_input};
			split_sync <= {split_sync[0], split_cap_mode};
			done_sync  <= {done_sync[0], trim_complete};
		end
	end

	// Edge taken between second and third stage only
	assign fault_event = fault_sync[1] & ~fault_sync[2];

	// ==========================================
	// Registers
	logic [7:0] sys_ctrl;
	logic [7:0] shutdown_group_select;
	logic [7:0] split_cap_charge_period;
	logic [7:0] backend_fault_reset_period;
	logic       trim_field;
	logic [7:0] next_sys_ctrl;
	logic [7:0] next_group_sel;
	logic [7:0] next_charge;
	logic [7:0] next_fault_period;
	logic       next_trim_field;
	logic       next_trim_start;
	logic [7:0] next_rd_data;
	logic       next_rd_valid;

	always_comb
	begin
		next_sys_ctrl     = sys_ctrl;
		next_group_sel    = shutdown_group_select;
		next_charge       = split_cap_charge_period;
		next_fault_period = backend_fault_reset_period;
		next_trim_field   = trim_field;
		next_trim_start   = 1'b0;
		next_rd_data      = rd_data;
		next_rd_valid     = reg_req.rd;
		// Grouping is taken as written; the host keeps it stable
		// while running, otherwise outputs may glitch
		if (reg_req.wr)
		begin
			case (reg_req.addr)
				OFS_SYS_CTRL:    next_sys_ctrl = reg_req.wdata;
				OFS_GROUP_SEL:   next_group_sel = reg_req.wdata;
				OFS_CHARGE:      next_charge = reg_req.wdata;
				OFS_FAULT_RESET: next_fault_period = reg_req.wdata;
				OFS_TRIM:
				begin
					next_trim_field = reg_req.wdata[TRIM_FIELD_BIT];
					next_trim_start = reg_req.wdata[TRIM_CMD_BIT];
				end
				default: next_sys_ctrl = sys_ctrl;
			endcase
		end
		if (reg_req.rd)
		begin
			case (reg_req.addr)
				OFS_SYS_CTRL:    next_rd_data = sys_ctrl;
				OFS_GROUP_SEL:   next_rd_data = shutdown_group_select;
				OFS_CHARGE:      next_rd_data = split_cap_charge_period;
				OFS_FAULT_RESET: next_rd_data = backend_fault_reset_period;
				OFS_TRIM:
				begin
					next_rd_data = 8'h00;
					next_rd_data[TRIM_DONE_BIT]  = done_sync[1];
					next_rd_data[TRIM_FIELD_BIT] = trim_field;
				end
				default: next_rd_data = 8'h00;
			endcase
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			sys_ctrl                   <= SYS_CTRL_RESET;
			shutdown_group_select      <= GROUP_SEL_RESET;
			split_cap_charge_period    <= CHARGE_RESET;
			backend_fault_reset_period <= FAULT_RESET_RESET;
			trim_field                 <= 1'b0;
			trim_start                 <= 1'b0;
			rd_data                    <= 8'h00;
			rd_valid                   <= 1'b0;
		end
		else if (ce)
		begin
			sys_ctrl                   <= next_sys_ctrl;
			shutdown_group_select      <= next_group_sel;
			split_cap_charge_period    <= next_charge;
			backend_fault_reset_period <= next_fault_period;
			trim_field                 <= next_trim_field;
			trim_start                 <= next_trim_start;
			rd_data                    <= next_rd_data;
			rd_valid                   <= next_rd_valid;
		end
	end

	assign trim_field_select = trim_field;

	// ==========================================
	// Start and fault sequencing
	seq_state_t        state;
	seq_state_t        next_state;
	logic              timer_start;
	logic [TICK_W-1:0] timer_ticks;
	logic              timer_done;
	logic              shutdown_req;
	logic              surround;
	logic [TICK_W-1:0] charge_len;
	logic              g1;
	logic              g2;
	logic [NUM_CHANNELS-1:0] en;
	logic              next_g1;
	logic              next_g2;
	logic [NUM_CHANNELS-1:0] next_en;

	assign shutdown_req = sys_ctrl[SYS_SHUTDOWN_BIT];
	assign surround     = sys_ctrl[SYS_SURROUND_BIT];
	assign charge_len   = charge_ticks(split_cap_charge_period[4:0]);

	period_timer #(
		.TICK_LEN (TICK_LEN)
	) u_timer (
		.core_clk (core_clk),
		.rst      (rst),
		.ce       (ce),
		.start    (timer_start),
		.ticks    (timer_ticks),
		.busy     (),
		.done     (timer_done)
	);

	always_comb
	begin
		next_state  = state;
		timer_start = 1'b0;
		timer_ticks = '0;
		case (state)
			ST_SHUTDOWN:
			begin
				if (!shutdown_req)
				begin
					if (split_sync[1] && charge_len != '0)
					begin
						timer_start = 1'b1;
						timer_ticks = charge_len;
						next_state  = ST_CHARGE;
					end
					else
						next_state = ST_RUN;
				end
			end
			ST_CHARGE:
			begin
				if (shutdown_req)
					next_state = ST_SHUTDOWN;
				else if (timer_done)
					next_state = ST_RUN;
			end
			ST_RUN:
			begin
				if (shutdown_req)
					next_state = ST_SHUTDOWN;
				else if (fault_event)
				begin
					timer_start = 1'b1;
					timer_ticks = fault_ticks(backend_fault_reset_period[3:0]);
					next_state  = ST_FAULT_HOLD;
				end
			end
			ST_FAULT_HOLD:
			begin
				if (fault_event)
				begin
					// A repeated fault restarts the hold
					timer_start = 1'b1;
					timer_ticks = fault_ticks(backend_fault_reset_period[3:0]);
				end
				else if (timer_done)
					next_state = shutdown_req ? ST_SHUTDOWN : ST_RUN;
			end
			default: next_state = ST_SHUTDOWN;
		endcase
	end

	// Stage outputs registered from the next state, so they track it
	always_comb
	begin
		next_g1 = 1'b0;
		next_g2 = 1'b0;
		next_en = '0;
		// Shutdown, charge and fault hold keep everything low
		if (next_state == ST_RUN)
		begin
			next_g2 = 1'b1;
			next_g1 = surround;
			for (int i = 0; i < NUM_CHANNELS; i++)
				next_en[i] = shutdown_group_select[i] ? next_g1 : next_g2;
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			state <= ST_SHUTDOWN;
			g1    <= 1'b0;
			g2    <= 1'b0;
			en    <= '0;
		end
		else if (ce)
		begin
			state <= next_state;
			g1    <= next_g1;
			g2    <= next_g2;
			en    <= next_en;
		end
	end

	assign group1_stage_reset = g1;
	assign group2_stage_reset = g2;
	assign pwm_enable         = en;

endmodule

// *** sim/stage_sequencer_checker.sv ***
`timescale 1ns/1ns
module stage_sequencer_checker
	import stage_seq_pkg::*;
#(
	parameter int TICK_LEN = TICK_CYCLES
)(
	input wire logic                     core_clk,
	input wire logic                     rst,
	input wire stage_seq_pkg::reg_req_t  reg_req,
	input wire logic [7:0]               rd_data,
	input wire logic                     backend_fault_input,
	input wire logic                     split_cap_mode,
	input wire logic                     trim_complete,
	input wire logic                     trim_start,
	input wire logic                     trim_field_select,
	input wire logic                     group1_stage_reset,
	input wire logic                     group2_stage_reset,
	input wire logic [NUM_CHANNELS-1:0]  pwm_enable
);
	logic [5:0] grp;
	logic [5:0] next_grp;
	logic       off;
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	// ==========================================
	// Grouping shadow
	always_comb
	begin
		next_grp = grp;
		if (reg_req.wr && reg_req.addr == OFS_GROUP_SEL)
			next_grp = reg_req.wdata[5:0];
	end
	always_ff @(posedge core_clk)
		grp <= rst ? 6'h00 : next_grp;
	assign off = !group1_stage_reset && !group2_stage_reset && pwm_enable == '0;
	// ==========================================
	// Steps
	sequence sys_wr;
		reg_req.wr && reg_req.addr == OFS_SYS_CTRL;
	endsequence
	sequence trim_wr;
		reg_req.wr && reg_req.addr == OFS_TRIM;
	endsequence
	sequence done_rd;
		trim_complete [*4] ##0 (reg_req.rd && reg_req.addr == OFS_TRIM);
	endsequence
	// ==========================================
	// Properties
	pwm_group_a: assert property (
		pwm_enable == ((grp & {6{group1_stage_reset}})
		| (~grp & {6{group2_stage_reset}})))
		else $error("pwm enables disagree with grouping");
	group_order_a: assert property (
		group1_stage_reset |-> group2_stage_reset)
		else $error("group 1 released without group 2");
	narrow_mode_a: assert property (
		sys_wr ##0 !reg_req.wdata[SYS_SURROUND_BIT] |-> ##3 !group1_stage_reset)
		else $error("group 1 released in narrow mode");
	shutdown_off_a: assert property (
		sys_wr ##0 reg_req.wdata[SYS_SHUTDOWN_BIT] |-> ##3 off)
		else $error("outputs alive after shutdown");
	quick_start_a: assert property (
		sys_wr ##0 (reg_req.wdata == 8'h20 && !split_cap_mode
		&& !backend_fault_input) |-> ##3 (group1_stage_reset && group2_stage_reset))
		else $error("start without split cap delayed");
	fault_drop_a: assert property (
		$rose(backend_fault_input) |-> ##[1:5] off)
		else $error("outputs alive after fault");
	trim_pulse_a: assert property (
		trim_wr ##0 reg_req.wdata[TRIM_CMD_BIT] |-> ##[1:2] trim_start ##1 !trim_start)
		else $error("trim command pulse wrong");
	trim_select_a: assert property (
		trim_wr |-> ##2 trim_field_select == $past(reg_req.wdata[TRIM_FIELD_BIT], 2))
		else $error("trim select does not follow write");
	trim_done_a: assert property (
		done_rd |=> rd_data[TRIM_DONE_BIT])
		else $error("trim done flag not read back");
endmodule

bind stage_sequencer stage_sequencer_checker #(.TICK_LEN(TICK_LEN)) i_chk (
	.core_clk(core_clk), .rst(rst), .reg_req(reg_req), .rd_data(rd_data),
	.backend_fault_input(backend_fault_input), .split_cap_mode(split_cap_mode),
	.trim_complete(trim_complete), .trim_start(trim_start),
	.trim_field_select(trim_field_select), .pwm_enable(pwm_enable),
	.group1_stage_reset(group1_stage_reset),
	.group2_stage_reset(group2_stage_reset));

// *** sim/power_stage_model.sv ***
`timescale 1ns/1ns
module power_stage_model
	import stage_seq_pkg::*;
(
	input  wire logic                                core_clk,
	input  wire logic                                group1_stage_reset,
	input  wire logic                                group2_stage_reset,
	input  wire logic [stage_seq_pkg::NUM_CHANNELS-1:0] pwm_enable,
	input  wire logic                                trip,
	output logic                                     fault
);
	// Error latches until every stage is held in reset, like a real stage
	always_ff @(posedge core_clk)
		fault <= trip | (fault & (group1_stage_reset | group2_stage_reset
			| (|pwm_enable)));
endmodule

// *** sim/test_stage_sequencer.sv ***
`timescale 1ns/1ns
module test_stage_sequencer;
	import stage_seq_pkg::*;
	localparam int TL = 2;
	logic       core_clk, rst, ce, trip, split_cap_mode, trim_complete;
	logic       rd_valid, fault, trim_start, trim_field_select, g1, g2;
	logic [7:0] rd_data;
	logic [7:0] exp_q[$];
	logic [5:0] pwm, grp;
	reg_req_t   req;
	int         fail_count, n_compared, seed, n0, n1, t;
	int         fcode[5] = '{0, 1, 9, 10, 15};
	int         fticks[5] = '{1, 13, 117, 130, 130};
	logic [7:0] ccode[3] = '{8'h04, 8'h08, 8'h10};
	int         cticks[3] = '{0, 130, 1300};

	stage_sequencer #(.TICK_LEN(TL)) i_stage_sequencer (
		.core_clk(core_clk), .rst(rst), .ce(ce), .reg_req(req),
		.rd_data(rd_data), .rd_valid(rd_valid), .backend_fault_input(fault),
		.split_cap_mode(split_cap_mode), .trim_complete(trim_complete),
		.trim_start(trim_start), .trim_field_select(trim_field_select),
		.group1_stage_reset(g1), .group2_stage_reset(g2), .pwm_enable(pwm));
	power_stage_model i_power_stage_model (.core_clk(core_clk),
		.group1_stage_reset(g1), .group2_stage_reset(g2), .pwm_enable(pwm),
		.trip(trip), .fault(fault));

	// ==========================================
	// Tasks
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("[FAIL] %0t seen %0h expected %0h", $time, seen, exp);
		end
	endtask
	task automatic idle(input int k);
		repeat (k) @(posedge core_clk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk);
		req.wr <= 1'b1;
		req.addr <= a;
		req.wdata <= d;
		@(posedge core_clk);
		req.wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		@(posedge core_clk);
		req.rd <= 1'b1;
		req.addr <= a;
		@(posedge core_clk);
		req.rd <= 1'b0;
	endtask
	// Bounded wait for group 2 release to reach a level
	task automatic wait_lvl(input logic lvl, output int c);
		c = 0;
		while (g2 !== lvl && c < 30000)
		begin
			@(posedge core_clk);
			c++;
		end
	endtask
	task automatic close_out;
		$display("compared %0d failed %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	always @(posedge core_clk)
		if (rd_valid === 1'b1)
			check(rd_data, exp_q.size() > 0 ? exp_q.pop_front() : 8'hxx);

	initial
	begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end
	initial
	begin
		#(8 * 40000);
		fail_count++;
		close_out;
	end

	// ==========================================
	// Scenarios
	initial
	begin
		rst = 1'b1;
		ce = 1'b1;
		trip = 1'b0;
		split_cap_mode = 1'b0;
		trim_complete = 1'b0;
		req = '0;
		seed = 32'h37d2;
		idle(10);
		rst <= 1'b0;
		idle(2);
		check({g1, g2, pwm}, 8'h00);
		rd(OFS_SYS_CTRL, SYS_CTRL_RESET);
		rd(OFS_GROUP_SEL, GROUP_SEL_RESET);
		rd(OFS_CHARGE, CHARGE_RESET);
		rd(OFS_FAULT_RESET, FAULT_RESET_RESET);
		rd(OFS_TRIM, 8'h00);
		wr(8'h00, 8'h6d);
		wr(OFS_TRIM, 8'h03);
		idle(1);
		check(trim_start, 1'b1);
		idle(2);
		check(trim_start, 1'b0);
		check(trim_field_select, 1'b1);
		rd(OFS_TRIM, 8'h02);
		trim_complete <= 1'b1;
		idle(6);
		rd(OFS_TRIM, 8'h42);
		for (int i = 0; i < 4; i++)
		begin
			grp = 6'($random(seed));
			wr(OFS_GROUP_SEL, {2'h0, grp});
			rd(OFS_GROUP_SEL, {2'h0, grp});
			// Mode bit moves only while shut down
			wr(OFS_SYS_CTRL, 8'h40);
			wr(OFS_SYS_CTRL, 8'h00);
			idle(4);
			check({g1, g2, pwm}, {2'b01, ~grp});
			wr(OFS_SYS_CTRL, 8'h40);
			wr(OFS_SYS_CTRL, 8'h60);
			wr(OFS_SYS_CTRL, 8'h20);
			idle(4);
			check({g1, g2, pwm}, 8'hff);
			wr(OFS_SYS_CTRL, 8'h60);
			idle(4);
			check({g1, g2, pwm}, 8'h00);
		end
		split_cap_mode <= 1'b1;
		foreach (ccode[k])
		begin
			t = cticks[k] * TL;
			wr(OFS_CHARGE, ccode[k]);
			rd(OFS_CHARGE, ccode[k]);
			wr(OFS_SYS_CTRL, 8'h20);
			// Frozen enable must hold off both the start and the timer
			ce <= 1'b0;
			idle(20);
			check({g1, g2, pwm}, 8'h00);
			ce <= 1'b1;
			wait_lvl(1'b1, n1);
			check(n1 >= t - 1 && n1 <= t + 6, 1'b1);
			wr(OFS_SYS_CTRL, 8'h60);
			idle(4);
		end
		split_cap_mode <= 1'b0;
		wr(OFS_SYS_CTRL, 8'h20);
		idle(4);
		foreach (fcode[k])
		begin
			t = fticks[k] * TL;
			wr(OFS_FAULT_RESET, 8'(fcode[k]));
			rd(OFS_FAULT_RESET, 8'(fcode[k]));
			trip <= 1'b1;
			@(posedge core_clk);
			trip <= 1'b0;
			wait_lvl(1'b0, n0);
			check(n0 <= 6, 1'b1);
			wait_lvl(1'b1, n1);
			check(n0 + n1 >= t && n0 + n1 <= t + 10, 1'b1);
			idle(2);
			check({g1, g2, pwm}, 8'hff);
		end
		rst <= 1'b1;
		idle(2);
		rst <= 1'b0;
		wr(8'h00, 8'h6d);
		wr(OFS_TRIM, 8'h01);
		rd(8'h27, 8'h00);
		// Only the low byte of each word fits this 8-bit port
		wr(8'hf8, 8'ha5);
		wr(8'hc9, 8'hef);
		wr(8'hca, 8'h00);
		wr(8'hc9, 8'hf1);
		wr(8'hca, 8'h00);
		rd(OFS_GROUP_SEL, GROUP_SEL_RESET);
		idle(3);
		check(trim_field_select, 1'b0);
		rd(OFS_TRIM, 8'h40);
		idle(4);
		check(exp_q.size(), 0);
		close_out;
	end
endmodule
